// File: bench/drive_mode_asserts.sv
/*
 * Port checker for the drive mode and menu controller.
 * Assumes it is bound to the design top with one clock domain.
 */
module drive_mode_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // keypad and settings
    input wire logic key_manual,
    input wire logic key_halt,
    input wire logic key_home,
    input wire logic key_up,
    input wire logic key_down,
    input wire logic key_enter,
    input wire logic up_held,
    input wire logic down_held,
    input wire logic remote_input_one,
    input wire logic remote_input_two,
    input wire logic [1:0] app_profile,
    input wire logic [1:0] input_one_polarity,
    input wire logic [1:0] input_two_polarity,
    input wire logic run_lockout,
    input wire logic factory_restore,
    input wire logic retry_permit,
    input wire logic restart_due,
    // outputs
    input wire logic run_request,
    input wire logic fault_latched,
    input wire logic [1:0] op_mode,
    input wire logic [1:0] screen,
    input wire logic [2:0] menu_item
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire dflt = app_profile != 2'h2 && input_one_polarity == 2'h0 && input_two_polarity == 2'h0;
    wire qual = remote_input_one && !remote_input_two;
    AST_OFF_IDLE: assert property (op_mode == 2'h0 |-> !run_request)
        else $error("run request high in off mode");
    AST_AUTO_RUN: assert property (op_mode == 2'h1 && $past(op_mode) == 2'h1 && $past(dflt) && run_request
        |-> $past(qual)) else $error("auto run without qualified inputs");
    AST_AUTO_DROP: assert property (op_mode == 2'h1 && dflt && !qual |=> !run_request)
        else $error("auto run kept after input change");
    AST_HALT: assert property (key_halt |=> op_mode == 2'h0 && !run_request)
        else $error("halt key did not stop");
    AST_LOCKOUT: assert property (key_manual && run_lockout && op_mode != 2'h2 |=> op_mode != 2'h2)
        else $error("manual entered under lockout");
    AST_MANUAL_IN: assert property (key_manual && !run_lockout && !key_halt && !factory_restore
        |=> op_mode == 2'h2 && !run_request) else $error("manual key not taken");
    AST_HOME: assert property (key_home && screen == 2'h0 |=> screen == 2'h1)
        else $error("home key did not open menu");
    AST_WRAP: assert property (screen == 2'h1 && key_down && !key_up && !key_home && !key_enter
        && menu_item == 3'h4 |=> menu_item == 3'h0) else $error("menu did not wrap");
    AST_NO_RETRY: assert property (fault_latched && restart_due && !retry_permit && !(up_held && down_held)
        |=> fault_latched) else $error("fault cleared without retry permit");
endmodule
bind drive_mode_ctrl drive_mode_asserts u_chk (.*);

// File: bench/field_model.sv
/*
 * Behavioural remote pressure switches and held arrow keys.
 * Assumes levels change only at the falling clock edge.
 */
module field_model (
    // clock
    input wire logic clk,
    // requested states
    input wire logic [1:0] contacts,
    input wire logic chord,
    // toward the controller
    output logic remote_input_one,
    output logic remote_input_two,
    output logic up_held,
    output logic down_held
);
    timeunit 1ns;
    timeprecision 1ns;
    always @(negedge clk) begin
        remote_input_one <= contacts[0];
        remote_input_two <= contacts[1];
        up_held <= chord;
        down_held <= chord;
    end
endmodule

// File: bench/tb_top.sv
/*
 * Self-checking bench for the drive mode and menu controller.
 * Assumes the field model and checker files are compiled alongside.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [12:0] pk = 13'h0000;
    logic [1:0] contacts = 2'h0;
    logic [1:0] prof = 2'h0;
    logic [1:0] pol1 = 2'h0;
    logic [1:0] pol2 = 2'h0;
    logic chord = 1'b0;
    logic retry = 1'b0;
    logic lock = 1'b0;
    logic mot = 1'b0;
    logic [2:0] ftype = 3'h3;
    wire logic one, two, uh, dh, run_request, fault_latched, fault_clear;
    wire logic [1:0] op_mode, screen;
    wire logic [2:0] menu_item;
    wire logic [15:0] tally;
    wire logic [31:0] run_timer, on_timer;
    int error_cnt = 0;
    int n_checks = 0;
    always #25 clk = ~clk;
    field_model u_field (.clk(clk), .contacts(contacts), .chord(chord), .remote_input_one(one),
        .remote_input_two(two), .up_held(uh), .down_held(dh));
    drive_mode_ctrl u_dut (.clk(clk), .rst(rst), .key_auto(pk[0]), .key_manual(pk[1]), .key_halt(pk[2]),
        .key_run(pk[3]), .key_stop(pk[4]), .key_home(pk[5]), .key_enter(pk[6]), .key_back(pk[7]),
        .key_up(pk[8]), .key_down(pk[9]), .up_held(uh), .down_held(dh), .remote_input_one(one),
        .remote_input_two(two), .app_profile(prof), .input_one_polarity(pol1), .input_two_polarity(pol2),
        .retry_permit(retry), .run_lockout(lock), .factory_restore(pk[10]), .fault_event(pk[11]),
        .fault_type(ftype), .restart_due(pk[12]), .motor_running(mot), .tally_sel(ftype), .tally_count(tally),
        .run_request(run_request), .op_mode(op_mode), .fault_latched(fault_latched), .fault_clear(fault_clear),
        .screen(screen), .menu_item(menu_item), .run_timer(run_timer), .on_timer(on_timer));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // one-cycle key or event pulse, outputs settled on return except tally_count, which settles one cycle later
    task automatic press(input int k);
        @(negedge clk);
        pk[k] = 1'b1;
        @(negedge clk);
        pk = 13'h0000;
    endtask
    task automatic sw(input logic [1:0] v);
        contacts = v;
        repeat (3) @(negedge clk);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge clk);
        error_cnt++;
        complete_run();
    end
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        chk({op_mode, run_request, screen, menu_item}, 32'h0, "reset state");
        press(0);
        for (int i = 0; i < 4; i++) begin
            sw(i[1:0]);
            chk(run_request, i == 1, "auto default");
        end
        prof = 2'h2;
        for (int i = 0; i < 4; i++) begin
            sw(i[1:0]);
            chk(run_request, i == 0, "auto profile");
        end
        prof = 2'h0;
        for (int p = 1; p < 3; p++) begin
            pol1 = p[1:0];
            pol2 = p[1:0];
            for (int i = 0; i < 4; i++) begin
                sw(i[1:0]);
                chk(run_request, p == 1 ? i == 3 : i == 0, "auto polarity");
            end
        end
        pol1 = 2'h0;
        pol2 = 2'h0;
        sw(2'h1);
        chk(run_request, 1'b1, "auto run");
        press(2);
        chk({op_mode, run_request}, 32'h0, "halt");
        sw(2'h1);
        chk(run_request, 1'b0, "off stays");
        $display("test auto modes done");
        lock = 1'b1;
        press(1);
        chk(op_mode, 2'h0, "lockout");
        lock = 1'b0;
        press(1);
        chk({op_mode, run_request}, 3'h4, "manual entry");
        press(3);
        sw(2'h2);
        chk(run_request, 1'b1, "manual run");
        mot = 1'b1;
        press(11);
        chk({fault_latched, run_request}, 2'h2, "fault stop");
        press(11);
        chord = 1'b1;
        repeat (100) @(negedge clk);
        chk(fault_latched, 1'b1, "chord too short");
        chord = 1'b0;
        press(12);
        chk(tally, 16'h0002, "tally");
        chk(fault_latched, 1'b1, "no retry");
        chk(fault_clear, 1'b0, "no retry pulse");
        retry = 1'b1;
        press(12);
        chk(fault_latched, 1'b0, "retry");
        chk(fault_clear, 1'b1, "retry pulse");
        press(4);
        mot = 1'b0;
        $display("test manual and faults done");
        press(5);
        chk(screen, 2'h1, "home");
        press(8);
        chk(menu_item, 3'h4, "wrap up");
        press(9);
        chk(menu_item, 3'h0, "wrap down");
        press(9);
        chk(menu_item, 3'h1, "step");
        press(6);
        chk(screen, 2'h2, "enter");
        press(7);
        chk(screen, 2'h1, "back");
        press(6);
        press(6);
        @(negedge clk);
        chk(screen, 2'h1, "wipe return");
        chk(tally, 16'h0000, "wipe tally");
        chk(run_timer, 32'h0, "wipe timer");
        chk(on_timer, 32'h1, "wipe on timer");
        press(5);
        chk(screen, 2'h0, "home back");
        press(10);
        chk(op_mode, 2'h0, "restore");
        $display("test menu done");
        complete_run();
    end
endmodule

// File: include/drive_ctrl_pkg.sv
/*
 * Shared constants and types for the drive mode and menu controller.
 * Assumes a single 20 MHz system clock.
 */
package drive_ctrl_pkg;
    localparam int CLK_HZ = 20000000;
    localparam int CHORD_HOLD_MS = 1000;
    localparam int CHORD_HOLD_CYCLES = (CLK_HZ / 1000) * CHORD_HOLD_MS;
    localparam int CHORD_CNT_W = 25;
    localparam int FAULT_TYPES = 8;
    localparam int FAULT_IDX_W = 3;
    localparam int TALLY_W = 16;
    localparam int TIMER_W = 32;
    localparam int MENU_ITEMS = 5;
    localparam logic [2:0] MENU_CHANGE_PARAMS = 3'h0;
    localparam logic [2:0] MENU_CLEAR_MEMORY = 3'h1;
    localparam logic [2:0] MENU_RESTART_LOG = 3'h2;
    localparam logic [2:0] MENU_READ_TIMERS = 3'h3;
    localparam logic [2:0] MENU_MEASURED = 3'h4;
    localparam logic [2:0] MENU_LAST = 3'h4;
    localparam logic [2:0] MENU_RESET_VALUE = 3'h0;
    localparam logic [1:0] PROFILE_ANALOG_CP = 2'h2;
    localparam logic [1:0] POL_DEFAULT = 2'h0;
    localparam logic [1:0] POL_CLOSED_RUN = 2'h1;
    localparam logic [1:0] POL_OPEN_RUN = 2'h2;
    typedef enum logic [1:0] {MODE_OFF, MODE_AUTO, MODE_MANUAL} op_mode_type;
    typedef enum logic [1:0] {SCREEN_STATUS, SCREEN_MENU, SCREEN_ITEM} screen_type;
endpackage

// File: rtl/drive_mode_ctrl.sv
/*
 * Operating-mode controller and keypad menu navigator for a motor drive.
 * Assumes key inputs are debounced one-cycle press pulses, except the held
 * up/down levels, and that all inputs are synchronous to clk.
 */
module drive_mode_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // keypad presses (one-cycle pulses)
    input wire logic key_auto,
    input wire logic key_manual,
    input wire logic key_halt,
    input wire logic key_run,
    input wire logic key_stop,
    input wire logic key_home,
    input wire logic key_enter,
    input wire logic key_back,
    input wire logic key_up,
    input wire logic key_down,
    // keypad held levels
    input wire logic up_held,
    input wire logic down_held,
    // remote switches, high when closed
    input wire logic remote_input_one,
    input wire logic remote_input_two,
    // settings
    input wire logic [1:0] app_profile,
    input wire logic [1:0] input_one_polarity,
    input wire logic [1:0] input_two_polarity,
    input wire logic retry_permit,
    input wire logic run_lockout,
    input wire logic factory_restore,
    // faults
    input wire logic fault_event,
    input wire logic [drive_ctrl_pkg::FAULT_IDX_W-1:0] fault_type,
    input wire logic restart_due,
    input wire logic motor_running,
    // tally view
    input wire logic [drive_ctrl_pkg::FAULT_IDX_W-1:0] tally_sel,
    output logic [drive_ctrl_pkg::TALLY_W-1:0] tally_count,
    // outputs
    output logic run_request,
    output logic [1:0] op_mode,
    output logic fault_latched,
    output logic fault_clear,
    output logic [1:0] screen,
    output logic [2:0] menu_item,
    output logic [drive_ctrl_pkg::TIMER_W-1:0] run_timer,
    output logic [drive_ctrl_pkg::TIMER_W-1:0] on_timer
);
    drive_ctrl_pkg::op_mode_type mode_reg, mode_next;
    drive_ctrl_pkg::screen_type screen_reg, screen_next;
    logic [2:0] item_reg, item_next;
    logic run_reg, run_next;
    logic manual_run_reg, manual_run_next;
    logic fault_reg, fault_next;
    logic clr_reg, clr_next;
    logic [drive_ctrl_pkg::CHORD_CNT_W-1:0] chord_reg, chord_next;
    logic [drive_ctrl_pkg::TIMER_W-1:0] run_t_reg, run_t_next;
    logic [drive_ctrl_pkg::TIMER_W-1:0] on_t_reg, on_t_next;
    logic wipe;
    logic one_ok, two_ok;
    logic chord_done;

    // decide whether an input level qualifies for running
    function automatic logic qualifies(input logic closed, input logic [1:0] pol,
                                       input logic dflt_closed_run);
        logic closed_run;
        closed_run = dflt_closed_run;
        if (pol == drive_ctrl_pkg::POL_CLOSED_RUN) begin
            closed_run = 1'b1;
        end else if (pol == drive_ctrl_pkg::POL_OPEN_RUN) begin
            closed_run = 1'b0;
        end
        return closed_run ? closed : ~closed;
    endfunction

    // step through menu items, wrapping at both ends
    function automatic logic [2:0] step_item(input logic [2:0] item, input logic forward);
        logic [2:0] stepped;
        if (forward) begin
            stepped = (item == drive_ctrl_pkg::MENU_LAST) ? 3'h0 : item + 3'h1;
        end else begin
            stepped = (item == 3'h0) ? drive_ctrl_pkg::MENU_LAST : item - 3'h1;
        end
        return stepped;
    endfunction

    always_comb begin
        one_ok = qualifies(remote_input_one, input_one_polarity,
                           app_profile != drive_ctrl_pkg::PROFILE_ANALOG_CP);
        two_ok = qualifies(remote_input_two, input_two_polarity, 1'b0);
    end

    always_comb begin
        chord_next = '0;
        if (up_held && down_held) begin
            chord_next = chord_reg;
            // saturate so one long hold clears only once
            if (chord_reg != drive_ctrl_pkg::CHORD_CNT_W'(drive_ctrl_pkg::CHORD_HOLD_CYCLES)) begin
                chord_next = chord_reg + 1'b1;
            end
        end
        chord_done = up_held && down_held &&
                     chord_reg == drive_ctrl_pkg::CHORD_CNT_W'(drive_ctrl_pkg::CHORD_HOLD_CYCLES - 1);
    end

    // mode and run request
    always_comb begin
        mode_next = mode_reg;
        manual_run_next = manual_run_reg;
        fault_next = fault_reg;
        clr_next = 1'b0;
        // fault latches; set wins over clear
        if (fault_event) begin
            fault_next = 1'b1;
        end else if (chord_done && fault_reg) begin
            fault_next = 1'b0;
            clr_next = 1'b1;
        end else if (restart_due && retry_permit && fault_reg) begin
            fault_next = 1'b0;
            clr_next = 1'b1;
        end
        if (factory_restore) begin
            mode_next = drive_ctrl_pkg::MODE_OFF;
            manual_run_next = 1'b0;
        end else if (key_halt) begin
            mode_next = drive_ctrl_pkg::MODE_OFF;
            manual_run_next = 1'b0;
        end else if (key_manual && !run_lockout) begin
            mode_next = drive_ctrl_pkg::MODE_MANUAL;
            manual_run_next = 1'b0;
        end else if (key_auto) begin
            mode_next = drive_ctrl_pkg::MODE_AUTO;
        end else if (mode_reg == drive_ctrl_pkg::MODE_MANUAL) begin
            if (key_stop) begin
                manual_run_next = 1'b0;
            end else if (key_run) begin
                manual_run_next = 1'b1;
            end
        end
        // run follows the next mode so a key acts in one cycle
        case (mode_next)
            drive_ctrl_pkg::MODE_AUTO: run_next = one_ok && two_ok && !fault_next;
            drive_ctrl_pkg::MODE_MANUAL: run_next = manual_run_next && !fault_next;
            drive_ctrl_pkg::MODE_OFF: run_next = 1'b0;
            default: run_next = 1'b0;
        endcase
    end

    // menu navigation
    always_comb begin
        screen_next = screen_reg;
        item_next = item_reg;
        wipe = 1'b0;
        case (screen_reg)
            drive_ctrl_pkg::SCREEN_STATUS: begin
                if (key_home) begin
                    screen_next = drive_ctrl_pkg::SCREEN_MENU;
                end
            end
            drive_ctrl_pkg::SCREEN_MENU: begin
                if (key_home) begin
                    screen_next = drive_ctrl_pkg::SCREEN_STATUS;
                end else if (key_enter) begin
                    screen_next = drive_ctrl_pkg::SCREEN_ITEM;
                end else if (key_down && !key_up) begin
                    item_next = step_item(item_reg, 1'b1);
                end else if (key_up && !key_down) begin
                    item_next = step_item(item_reg, 1'b0);
                end
            end
            drive_ctrl_pkg::SCREEN_ITEM: begin
                if (key_home) begin
                    screen_next = drive_ctrl_pkg::SCREEN_STATUS;
                end else if (key_back) begin
                    screen_next = drive_ctrl_pkg::SCREEN_MENU;
                end else if (key_enter && item_reg == drive_ctrl_pkg::MENU_CLEAR_MEMORY) begin
                    wipe = 1'b1;
                    screen_next = drive_ctrl_pkg::SCREEN_MENU;
                end
            end
            default: screen_next = drive_ctrl_pkg::SCREEN_STATUS;
        endcase
    end

    // resettable timers
    always_comb begin
        run_t_next = run_t_reg;
        // drive on time counts every cycle
        on_t_next = on_t_reg + 1'b1;
        if (motor_running) begin
            run_t_next = run_t_reg + 1'b1;
        end
        if (wipe) begin
            run_t_next = '0;
            on_t_next = '0;
        end
    end

    // chord hold counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chord_reg <= '0;
        end else begin
            chord_reg <= chord_next;
        end
    end

    // mode, run and fault state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_reg <= drive_ctrl_pkg::MODE_OFF;
            manual_run_reg <= 1'b0;
            run_reg <= 1'b0;
            fault_reg <= 1'b0;
            clr_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            manual_run_reg <= manual_run_next;
            run_reg <= run_next;
            fault_reg <= fault_next;
            clr_reg <= clr_next;
        end
    end

    // menu state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            screen_reg <= drive_ctrl_pkg::SCREEN_STATUS;
            item_reg <= drive_ctrl_pkg::MENU_RESET_VALUE;
        end else begin
            screen_reg <= screen_next;
            item_reg <= item_next;
        end
    end

    // timer state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_t_reg <= '0;
            on_t_reg <= '0;
        end else begin
            run_t_reg <= run_t_next;
            on_t_reg <= on_t_next;
        end
    end

    // per-type fault occurrence counts
    fault_tally_mem tally (
        .clk(clk),
        .rst(rst),
        .bump(fault_event),
        .bump_idx(fault_type),
        .wipe(wipe),
        .rd_idx(tally_sel),
        .rd_data(tally_count)
    );

    // outputs straight from registers
    assign run_request = run_reg;
    assign op_mode = mode_reg;
    assign fault_latched = fault_reg;
    assign fault_clear = clr_reg;
    assign screen = screen_reg;
    assign menu_item = item_reg;
    assign run_timer = run_t_reg;
    assign on_timer = on_t_reg;
endmodule

// File: rtl/fault_tally_mem.sv
/*
 * Per-fault-type occurrence counters in a small memory.
 * Assumes single-cycle pulses; a wipe wins over a bump.
 */
module fault_tally_mem (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // updates
    input wire logic bump,
    input wire logic [drive_ctrl_pkg::FAULT_IDX_W-1:0] bump_idx,
    input wire logic wipe,
    // read port
    input wire logic [drive_ctrl_pkg::FAULT_IDX_W-1:0] rd_idx,
    output logic [drive_ctrl_pkg::TALLY_W-1:0] rd_data
);
    logic [drive_ctrl_pkg::TALLY_W-1:0] tally_reg [drive_ctrl_pkg::FAULT_TYPES];
    logic [drive_ctrl_pkg::TALLY_W-1:0] tally_next [drive_ctrl_pkg::FAULT_TYPES];
    logic [drive_ctrl_pkg::TALLY_W-1:0] rd_next;

    always_comb begin
        for (int i = 0; i < drive_ctrl_pkg::FAULT_TYPES; i++) begin
            tally_next[i] = tally_reg[i];
            if (wipe) begin
                tally_next[i] = '0;
            end else if (bump && bump_idx == i[drive_ctrl_pkg::FAULT_IDX_W-1:0] && tally_reg[i] != '1) begin
                tally_next[i] = tally_reg[i] + 1'b1;
            end
        end
        rd_next = tally_reg[rd_idx];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < drive_ctrl_pkg::FAULT_TYPES; i++) begin
                tally_reg[i] <= '0;
            end
            rd_data <= '0;
        end else begin
            tally_reg <= tally_next;
            rd_data <= rd_next;
        end
    end
endmodule
